// >>> inc/plp_pkg.sv
// Purpose: shared constants and types for the power-loss supervisor
// Assumes: 100 MHz clk
// Notes: state codes are binary, 3 bits
package plp_pkg;
	localparam int unsigned clk_mhz = 100;
	localparam int unsigned softstart_ms = 10;
	localparam int unsigned softstart_cycles = softstart_ms * 1000 * clk_mhz;
	localparam int unsigned health_period_s = 240;
	localparam longint unsigned health_cycles = 64'(health_period_s) * 64'd1000000 * 64'(clk_mhz);
	localparam int unsigned health_run_us = 100;
	localparam int unsigned health_run_cycles = health_run_us * clk_mhz;

	typedef enum logic [2:0] {
		st_por = 3'h0,
		st_softstart = 3'h1,
		st_normal = 3'h2,
		st_health = 3'h3,
		st_backup = 3'h4,
		st_warn_halt = 3'h5,
		st_full_halt = 3'h6
	} op_state_t;

	localparam logic [2:0] en_ov_default = 3'h7;
	localparam int unsigned n_status = 16;
	localparam logic [15:0] mask_default = 16'h0000;
	localparam logic [15:0] status_default = 16'h0000;
	localparam int force_off_bit = 0;
	localparam int health_trig_bit = 1;
	localparam logic [7:0] ctrl_reg_addr = 8'h0a;
	localparam logic [7:0] state_reg_addr = 8'h00;
endpackage

// >>> rtl/plp_timer.sv
// Purpose: count cycles while enabled, pulse done on reaching limit
// Assumes: limit fits in 40 bits
// Notes: clear restarts the count
module plp_timer #(
	parameter logic [39:0] limit = 40'h1
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic run,
	output logic done
);
	typedef struct packed
	{
		logic [39:0] count;
		logic done;
	} timer_state_t;
	timer_state_t s, next_s;

	always_comb
	begin
		next_s = s;
		next_s.done = 1'b0;
		if (clear)
		begin
			next_s.count = 40'h0;
		end
		else if (run)
		begin
			if (s.count >= limit - 40'h1)
			begin
				next_s.count = 40'h0;
				next_s.done = 1'b1;
			end
			else
			begin
				next_s.count = s.count + 40'h1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s <= '0;
		end
		else
		begin
			s <= next_s;
		end
	end
	assign done = s.done;
endmodule // plp_timer

// >>> rtl/plp_sync.sv
// Purpose: two-flop synchroniser for a bus of pin levels
// Assumes: levels are quasi-static
// Notes: first stage feeds only the second
module plp_sync #(
	parameter int width = 1
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic [width-1:0] d,
	output logic [width-1:0] q
);
	typedef struct packed
	{
		logic [width-1:0] meta;
		logic [width-1:0] sync;
	} sync_state_t;
	sync_state_t s, next_s;

	always_comb
	begin
		next_s.meta = d;
		next_s.sync = s.meta;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s <= '0;
		end
		else
		begin
			s <= next_s;
		end
	end
	assign q = s.sync;
endmodule // plp_sync

// >>> rtl/power_loss_protection_fsm.sv
// Purpose: supervisory state machine of a power-loss-protection controller
// Assumes: comparator flags are asynchronous pins, host strobes are on clk
// Notes: register access is plain ports, no bus engine
module power_loss_protection_fsm (
	input wire logic clk,
	input wire logic rst,
	input wire logic enable_above_undervoltage,
	input wire logic [6:0] enable_above_ov_step,
	input wire logic input_above_lockout,
	input wire logic input_overvoltage,
	input wire logic input_undervoltage,
	input wire logic fuse_overcurrent,
	input wire logic fuse_current_warning,
	input wire logic diff_below_200mv,
	input wire logic diff_above_560mv,
	input wire logic storage_below_3v6,
	input wire logic storage_overvoltage,
	input wire logic storage_undervoltage,
	input wire logic buck_out_fault,
	input wire logic buck_op_fault,
	input wire logic buck_uv_shutdown,
	input wire logic ref_undervoltage,
	input wire logic temp_above_145c,
	input wire logic temp_above_155c,
	input wire logic regulator_fail,
	input wire logic boot_cap_fail,
	input wire logic health_done,
	input wire logic adc_data_ready,
	input wire logic adc_out_of_limit,
	input wire logic ctrl_write,
	input wire logic [7:0] ctrl_wdata,
	input wire logic ov_level_write,
	input wire logic [2:0] ov_level_wdata,
	input wire logic mask_write,
	input wire logic [15:0] mask_wdata,
	input wire logic status_read,
	output logic [2:0] current_state,
	output logic [1:0] ctrl_readback,
	output logic [2:0] enable_pin_overvoltage_level,
	output logic [15:0] fault_status,
	output logic fault_alert_n,
	output logic fuse_en,
	output logic boost_en,
	output logic buck_en,
	output logic adc_en,
	output logic ref_en,
	output logic health_active,
	output logic charge_start,
	output logic serial_reset,
	output logic reg_access_en
);
	localparam logic [39:0] soft_lim = 40'(plp_pkg::softstart_cycles);
	localparam logic [39:0] hlth_lim = 40'(plp_pkg::health_cycles);

	logic [23:0] raw_in, sy;
	logic soft_done, period_done;

	assign raw_in = {enable_above_undervoltage, enable_above_ov_step[6:0],
		input_above_lockout, input_overvoltage, input_undervoltage, fuse_overcurrent,
		fuse_current_warning, diff_below_200mv, diff_above_560mv, storage_below_3v6,
		storage_overvoltage, storage_undervoltage, buck_out_fault, buck_op_fault,
		buck_uv_shutdown, ref_undervoltage, temp_above_145c, temp_above_155c};

	plp_sync #(.width(24)) u_sync (
		.clk(clk),
		.rst(rst),
		.d(raw_in),
		.q(sy)
	);

	logic enable_undervoltage_threshold_ok, in_lock_ok, in_ov, in_uv, f_oc, f_warn, d_lo, d_hi;
	logic s_low, s_ov, s_uv, b_out, b_op, b_uvs, r_uv, t145, t155;
	logic [6:0] ov_step;
	assign {enable_undervoltage_threshold_ok, ov_step, in_lock_ok, in_ov, in_uv, f_oc, f_warn, d_lo, d_hi,
		s_low, s_ov, s_uv, b_out, b_op, b_uvs, r_uv, t145, t155} = sy;

	// misc fault and status pins not through the bus: sync locally
	logic [4:0] misc_sy;
	plp_sync #(.width(5)) u_sync2 (
		.clk(clk),
		.rst(rst),
		.d({regulator_fail, boot_cap_fail, health_done, adc_data_ready, adc_out_of_limit}),
		.q(misc_sy)
	);

	typedef struct packed
	{
		plp_pkg::op_state_t st;
		logic force_off;
		logic health_req;
		logic [2:0] ov_level;
		logic [15:0] mask;
		logic [15:0] status;
		logic [15:0] prev_src;
		logic alert_n;
		logic health_run;
		logic charge;
		logic serial_rst;
		logic [4:0] en;
		logic reg_access;
	} fsm_state_t;
	fsm_state_t s, next_s;

	// selected overvoltage threshold exceeded
	function automatic logic ov_hit(input logic [2:0] lvl, input logic [6:0] step);
		if (lvl == 3'h0)
			return 1'b0;
		return step[lvl - 3'h1];
	endfunction

	// enables {fuse, boost, buck, adc, ref}
	function automatic logic [4:0] enables(input plp_pkg::op_state_t st);
		unique case (st)
			plp_pkg::st_por: return 5'h00;
			plp_pkg::st_softstart: return 5'h11;
			plp_pkg::st_normal: return 5'h1b;
			plp_pkg::st_health: return 5'h1b;
			plp_pkg::st_backup: return 5'h07;
			plp_pkg::st_warn_halt: return 5'h13;
			plp_pkg::st_full_halt: return 5'h00;
			default: return 5'h00;
		endcase
	endfunction

	logic en_ov_hit, fuse_fault, warn_cause, regs_live;
	logic [15:0] src;
	assign en_ov_hit = ov_hit(s.ov_level, ov_step);
	assign fuse_fault = !enable_undervoltage_threshold_ok || en_ov_hit || in_ov || f_oc || d_hi;
	assign warn_cause = t145 || misc_sy[4] || misc_sy[3];
	assign regs_live = s.st != plp_pkg::st_full_halt && s.st != plp_pkg::st_por;
	assign src = {in_ov, in_uv, t145, t155, d_hi, f_warn, f_oc, s_ov, s_uv,
		s.st == plp_pkg::st_backup, b_op, b_uvs, r_uv, misc_sy[1], misc_sy[0], 1'b0};

	plp_timer #(.limit(soft_lim)) u_soft (
		.clk(clk),
		.rst(rst),
		.clear(s.st != plp_pkg::st_softstart),
		.run(d_lo),
		.done(soft_done)
	);

	plp_timer #(.limit(hlth_lim)) u_period (
		.clk(clk),
		.rst(rst),
		.clear(s.st != plp_pkg::st_normal && s.st != plp_pkg::st_health),
		.run(s.st == plp_pkg::st_normal),
		.done(period_done)
	);

	always_comb
	begin
		next_s = s;
		next_s.charge = 1'b0;
		next_s.serial_rst = 1'b0;
		if (regs_live && ctrl_write)
		begin
			if (ctrl_wdata[plp_pkg::force_off_bit])
				next_s.force_off = 1'b1;
			if (ctrl_wdata[plp_pkg::health_trig_bit])
				next_s.health_req = 1'b1;
		end
		if (regs_live && ov_level_write)
			next_s.ov_level = ov_level_wdata;
		if (regs_live && mask_write)
			next_s.mask = mask_wdata;
		// status: a change sets, a read reloads the unmasked active sources, set wins
		if (regs_live && status_read)
			next_s.status = src & ~s.mask;
		next_s.status = next_s.status | ((src ^ s.prev_src) & ~s.mask);
		next_s.prev_src = src;
		next_s.alert_n = ~|next_s.status;

		unique case (s.st)
			plp_pkg::st_por:
				if (enable_undervoltage_threshold_ok && in_lock_ok)
					next_s.st = plp_pkg::st_softstart;
			plp_pkg::st_softstart:
				if (s.force_off)
					next_s.st = plp_pkg::st_por;
				else if (t155)
					next_s.st = plp_pkg::st_full_halt;
				else if (warn_cause)
					next_s.st = plp_pkg::st_warn_halt;
				else if (soft_done && d_lo)
				begin
					next_s.st = plp_pkg::st_normal;
					next_s.charge = 1'b1;
				end
			plp_pkg::st_normal, plp_pkg::st_health:
				if (s.force_off)
					next_s.st = plp_pkg::st_por;
				else if (t155)
					next_s.st = plp_pkg::st_full_halt;
				else if (warn_cause)
					next_s.st = plp_pkg::st_warn_halt;
				else if (fuse_fault)
					next_s.st = plp_pkg::st_backup;
				else if (s.st == plp_pkg::st_normal && (period_done || s.health_req))
					next_s.st = plp_pkg::st_health;
				else if (s.st == plp_pkg::st_health && misc_sy[2])
				begin
					next_s.st = plp_pkg::st_normal;
					next_s.charge = 1'b1;
					// a trigger written in the finishing cycle survives
					if (!(ctrl_write && ctrl_wdata[plp_pkg::health_trig_bit]))
						next_s.health_req = 1'b0;
				end
			plp_pkg::st_backup:
				if (s.force_off || !enable_undervoltage_threshold_ok || s_low || b_out)
					next_s.st = plp_pkg::st_por;
				else if (t155)
					next_s.st = plp_pkg::st_full_halt;
				else if (warn_cause)
					next_s.st = plp_pkg::st_warn_halt;
			plp_pkg::st_warn_halt:
				if (s.force_off)
					next_s.st = plp_pkg::st_por;
				else if (t155)
					next_s.st = plp_pkg::st_full_halt;
				else if (!warn_cause)
				begin
					next_s.st = plp_pkg::st_normal;
					next_s.charge = 1'b1;
				end
			plp_pkg::st_full_halt:
				if (!t145 && !t155 && !f_oc)
					next_s.st = plp_pkg::st_softstart;
			default:
				next_s.st = plp_pkg::st_por;
		endcase
		if (next_s.st == plp_pkg::st_por && s.st != plp_pkg::st_por)
		begin
			next_s.serial_rst = 1'b1;
			next_s.force_off = 1'b0; // force_off and health_req cleared, other registers kept
			next_s.health_req = 1'b0;
		end
		next_s.health_run = next_s.st == plp_pkg::st_health;
		next_s.en = enables(next_s.st);
		next_s.reg_access = next_s.st != plp_pkg::st_full_halt
			&& next_s.st != plp_pkg::st_por;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s <= '0;
			s.st <= plp_pkg::st_por;
			s.ov_level <= plp_pkg::en_ov_default;
			s.mask <= plp_pkg::mask_default;
			s.status <= plp_pkg::status_default;
			s.alert_n <= 1'b1;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign current_state = s.st;
	assign ctrl_readback = {s.health_req, s.force_off};
	assign enable_pin_overvoltage_level = s.ov_level;
	assign fault_status = s.status;
	assign fault_alert_n = s.alert_n;
	assign {fuse_en, boost_en, buck_en, adc_en, ref_en} = s.en;
	assign health_active = s.health_run;
	assign charge_start = s.charge;
	assign serial_reset = s.serial_rst;
	assign reg_access_en = s.reg_access;
endmodule // power_loss_protection_fsm

// >>> verification/plp_props.sv
// Purpose: concurrent checks on the supervisor ports
// Assumes: enables follow the state code in the same cycle
// Notes: attached by bind
module power_loss_protection_fsm_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic ctrl_write,
	input wire logic [7:0] ctrl_wdata,
	input wire logic [2:0] current_state,
	input wire logic fuse_en,
	input wire logic boost_en,
	input wire logic buck_en,
	input wire logic adc_en,
	input wire logic ref_en,
	input wire logic charge_start,
	input wire logic serial_reset,
	input wire logic reg_access_en
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	logic [4:0] en;
	assign en = {fuse_en, boost_en, buck_en, adc_en, ref_en};
	sequence enter_por;
		current_state != plp_pkg::st_por ##1 current_state == plp_pkg::st_por;
	endsequence
	sequence enter_normal;
		current_state != plp_pkg::st_normal ##1 current_state == plp_pkg::st_normal;
	endsequence
	AST_POR_OFF: assert property (current_state == plp_pkg::st_por |-> en == 5'h00)
		else $error("enables on in reset state");
	AST_FULL_OFF: assert property (current_state == plp_pkg::st_full_halt |->
		en == 5'h00 && !reg_access_en) else $error("full halt not all off");
	AST_SOFT_EN: assert property (current_state == plp_pkg::st_softstart |-> en == 5'h11)
		else $error("softstart enables wrong");
	AST_NORM_EN: assert property (current_state inside {3'h2, 3'h3} |-> en == 5'h1b)
		else $error("normal enables wrong");
	AST_BACKUP_EN: assert property (current_state == plp_pkg::st_backup |-> en == 5'h07)
		else $error("backup enables wrong");
	AST_WARN_EN: assert property (current_state == plp_pkg::st_warn_halt |->
		en == 5'h13 && reg_access_en) else $error("warning halt enables wrong");
	AST_SERIAL_RST: assert property (enter_por |-> serial_reset)
		else $error("no serial reset on reset entry");
	AST_CHARGE: assert property (enter_normal |-> charge_start)
		else $error("no charge start on normal entry");
	AST_FORCE_OFF: assert property (ctrl_write && ctrl_wdata[0] && reg_access_en |->
		##[1:4] current_state == plp_pkg::st_por) else $error("force off ignored");
	AST_STATE_CODE: assert property (current_state != 3'h7)
		else $error("illegal state code");
endmodule // power_loss_protection_fsm_props
bind power_loss_protection_fsm power_loss_protection_fsm_props props (.clk, .rst, .ctrl_write,
	.ctrl_wdata, .current_state, .fuse_en, .boost_en, .buck_en, .adc_en, .ref_en,
	.charge_start, .serial_reset, .reg_access_en);

// >>> verification/plp_host_model.sv
// Purpose: host that answers the fault alert by reading status
// Assumes: strobes launched on the falling edge
// Notes: reads only while auto_ack is high
module plp_host_model (
	input wire logic clk,
	input wire logic auto_ack,
	input wire logic fault_alert_n,
	output logic status_read
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		status_read = 1'b0;
	end
	// one-cycle read pulse, then one idle cycle
	always @(negedge clk)
	begin
		status_read <= auto_ack && fault_alert_n === 1'b0 && !status_read;
	end
endmodule // plp_host_model

// >>> verification/power_loss_protection_fsm_tb.sv
// Purpose: scenario bench for the power-loss supervisor
// Assumes: softstart timer too long to expire, normal reached via warning halt
// Notes: inputs change on the falling edge
module power_loss_protection_fsm_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [21:0] fl = '0;
	logic [6:0] ov_step = '0;
	logic cw = 1'b0;
	logic ow = 1'b0;
	logic mw = 1'b0;
	logic [15:0] wd = '0;
	logic auto_ack = 1'b0;
	logic status_read, fault_alert_n, fuse_en, boost_en, buck_en, adc_en, ref_en;
	logic health_active, charge_start, serial_reset, reg_access_en;
	logic [2:0] current_state, ov_level;
	logic [1:0] ctrl_readback;
	logic [15:0] fault_status;
	int mismatches = 0;
	int comparisons = 0;
	always #5 clk = ~clk;
	power_loss_protection_fsm uut (.clk, .rst, .enable_above_undervoltage(fl[0]),
		.enable_above_ov_step(ov_step), .input_above_lockout(fl[1]),
		.input_overvoltage(fl[2]), .input_undervoltage(fl[3]), .fuse_overcurrent(fl[4]),
		.fuse_current_warning(fl[5]), .diff_below_200mv(fl[6]), .diff_above_560mv(fl[7]),
		.storage_below_3v6(fl[8]), .storage_overvoltage(fl[9]), .storage_undervoltage(fl[10]),
		.buck_out_fault(fl[11]), .buck_op_fault(fl[12]), .buck_uv_shutdown(fl[13]),
		.ref_undervoltage(fl[14]), .temp_above_145c(fl[15]), .temp_above_155c(fl[16]),
		.regulator_fail(fl[17]), .boot_cap_fail(fl[18]), .health_done(fl[19]),
		.adc_data_ready(fl[20]), .adc_out_of_limit(fl[21]), .ctrl_write(cw),
		.ctrl_wdata(wd[7:0]), .ov_level_write(ow), .ov_level_wdata(wd[2:0]), .mask_write(mw),
		.mask_wdata(wd), .status_read, .current_state, .ctrl_readback,
		.enable_pin_overvoltage_level(ov_level), .fault_status, .fault_alert_n, .fuse_en,
		.boost_en, .buck_en, .adc_en, .ref_en, .health_active, .charge_start, .serial_reset,
		.reg_access_en);
	plp_host_model host (.clk, .auto_ack, .fault_alert_n, .status_read);
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wait_on(input bit on_alert, input logic [2:0] v);
		logic [2:0] seen;
		for (int n = 0; n < 100; n++)
		begin
			seen = on_alert ? {2'b00, fault_alert_n} : current_state;
			if (seen === v)
				break;
			@(negedge clk);
		end
		check(on_alert ? "fault_alert_n" : "current_state", seen, v);
		if (seen !== v)
			report_and_stop();
	endtask
	task automatic strobe(input int which, input logic [15:0] d);
		@(negedge clk);
		wd = d;
		{cw, ow, mw} = {which == 0, which == 1, which == 2};
		@(negedge clk);
		{cw, ow, mw} = 3'b000;
	endtask
	task automatic t_start();
		check("state", current_state, plp_pkg::st_por);
		check("ov_level", ov_level, plp_pkg::en_ov_default);
		check("status", fault_status, plp_pkg::status_default);
		check("alert", fault_alert_n, 1'b1);
		fl[0] = 1'b1;
		fl[6] = 1'b1;
		repeat (10) @(negedge clk);
		check("state", current_state, plp_pkg::st_por);
		fl[1] = 1'b1;
		wait_on(0, plp_pkg::st_softstart);
		repeat (50) @(negedge clk);
		check("state", current_state, plp_pkg::st_softstart);
		$display("test start done");
	endtask
	task automatic t_alert();
		int src[8] = '{5, 9, 10, 12, 13, 14, 20, 21};
		int pos[8] = '{10, 8, 7, 5, 4, 3, 2, 1};
		auto_ack = 1'b1;
		for (int k = 0; k < 8; k++)
		begin
			fl[src[k]] = 1'b1;
			wait_on(1, 3'h0);
			check("status bit", fault_status[pos[k]], 1'b1);
			repeat (20) @(negedge clk);
			check("alert", fault_alert_n, 1'b0);
			fl[src[k]] = 1'b0;
			wait_on(1, 3'h1);
		end
		strobe(2, 16'h0400);
		fl[5] = 1'b1;
		repeat (20) @(negedge clk);
		check("alert", fault_alert_n, 1'b1);
		auto_ack = 1'b0;
		$display("test alert done");
	endtask
	task automatic t_force();
		strobe(0, 16'h0001);
		wait_on(0, plp_pkg::st_por);
		check("readback", ctrl_readback, 2'b00);
		wait_on(0, plp_pkg::st_softstart);
		$display("test force done");
	endtask
	task automatic t_full();
		strobe(1, 16'h0003);
		check("ov_level", ov_level, 3'h3);
		fl[16] = 1'b1;
		fl[4] = 1'b1;
		wait_on(0, plp_pkg::st_full_halt);
		check("reg_access", reg_access_en, 1'b0);
		fl[16] = 1'b0;
		repeat (20) @(negedge clk);
		check("state", current_state, plp_pkg::st_full_halt);
		fl[4] = 1'b0;
		wait_on(0, plp_pkg::st_softstart);
		check("ov_level", ov_level, 3'h3);
		$display("test full halt done");
	endtask
	task automatic t_warn();
		fl[15] = 1'b1;
		wait_on(0, plp_pkg::st_warn_halt);
		fl[15] = 1'b0;
		wait_on(0, plp_pkg::st_normal);
	endtask
	task automatic t_health();
		t_warn();
		strobe(0, 16'h0002);
		wait_on(0, plp_pkg::st_health);
		check("readback", ctrl_readback, 2'b10);
		check("health_active", health_active, 1'b1);
		fl[19] = 1'b1;
		wait_on(0, plp_pkg::st_normal);
		repeat (3) @(negedge clk);
		check("readback", ctrl_readback, 2'b00);
		fl[19] = 1'b0;
		strobe(0, 16'h0002);
		wait_on(0, plp_pkg::st_health);
		fl[7] = 1'b1;
		wait_on(0, plp_pkg::st_backup);
		fl[8] = 1'b1;
		wait_on(0, plp_pkg::st_por);
		check("ov_level", ov_level, 3'h3);
		fl[8:7] = 2'b00;
		wait_on(0, plp_pkg::st_softstart);
		$display("test health done");
	endtask
	task automatic t_ov();
		t_warn();
		strobe(1, 16'h0000);
		ov_step = 7'h7f;
		repeat (20) @(negedge clk);
		check("state", current_state, plp_pkg::st_normal);
		strobe(1, 16'h0003);
		wait_on(0, plp_pkg::st_backup);
		fl[0] = 1'b0;
		ov_step = 7'h00;
		wait_on(0, plp_pkg::st_por);
		$display("test overvoltage done");
	endtask
	initial
	begin
		repeat (2) @(negedge clk);
		rst = 1'b0;
		t_start();
		t_alert();
		t_force();
		t_full();
		t_health();
		t_ov();
		report_and_stop();
	end
endmodule // power_loss_protection_fsm_tb
